// File: design/dcm_pkg.sv
// shared constants, field layout and types of the dram configuration port
package dcm_pkg;
  localparam int          CFG_W       = 16;
  localparam int          AD_W        = 26;
  localparam int          DATA_W      = 32;
  localparam int          REF_W       = 9;
  localparam logic [15:0] CFG_RESET   = 16'h6CB0;
  localparam logic [15:0] CFG_RSVD    = 16'h8200;
  // field positions of the configuration register
  localparam int PAGE_SIZE_CODE_LO           = 0;
  localparam int INTERLEAVE_BIT              = 2;
  localparam int WRITE_NEAR_DISABLE_BIT      = 3;
  localparam int ROW_TO_COLUMN_DELAY_SEL_BIT = 4;
  localparam int ROW_TIMING_CODE_LO          = 5;
  localparam int COLUMN_WIDTH_SEL_BIT        = 8;
  localparam int COLUMN_PRECHARGE_SEL_BIT    = 10;
  localparam int REFRESH_CLOCK_CODE_LO       = 11;
  localparam int DELAYED_SELECT_SAMPLING_BIT = 14;
  // timing
  localparam logic [2:0] CFG_ACK_CYCLES     = 3'h3;
  localparam logic [2:0] PAGE_WR_MIN_FAST   = 3'h2;
  localparam logic [2:0] PAGE_WR_MIN_SLOW   = 3'h3;
  localparam logic [2:0] OTHER_CYCLES       = 3'h3;
  localparam int         REFRESH_MAX_NS     = 10000;
  localparam int         REF_MHZ [8]        = '{4, 8, 12, 16, 20, 25, 33, 40};
  // host register map
  localparam logic [7:0] REG_ADDR   = 8'h00;
  localparam logic [7:0] REG_DATA   = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDDATA = 8'h10;
  localparam int         CTRL_GO    = 0;
  localparam int         CTRL_KIND  = 1;
  localparam int         STAT_BUSY  = 0;
  localparam int         STAT_DONE  = 1;

  typedef enum logic [1:0] {
    K_MEMWR = 2'b00,
    K_MEMRD = 2'b01,
    K_CFGWR = 2'b10,
    K_OTHER = 2'b11
  } dcm_kind_t;

  // refresh reload in cycles of the programmed clock rate
  function automatic logic [REF_W-1:0] dcmRefReload(input logic [2:0] code);
    dcmRefReload = REF_W'(REFRESH_MAX_NS * REF_MHZ[code] / 1000);
  endfunction

  function automatic logic [2:0] dcmRasWidth(input logic [2:0] code);
    case (code)
      3'h0:    dcmRasWidth = 3'h2;
      3'h1:    dcmRasWidth = 3'h3;
      3'h2:    dcmRasWidth = 3'h3;
      default: dcmRasWidth = 3'h4;
    endcase
  endfunction

  function automatic logic [2:0] dcmRasPre(input logic [2:0] code);
    case (code)
      3'h0:    dcmRasPre = 3'h2;
      3'h1:    dcmRasPre = 3'h2;
      3'h2:    dcmRasPre = 3'h3;
      3'h3:    dcmRasPre = 3'h2;
      3'h4:    dcmRasPre = 3'h3;
      default: dcmRasPre = 3'h4;
    endcase
  endfunction
endpackage

// File: design/dcm_bus_if.sv
// processor local bus between the host end and the dram controller end
`timescale 1ns/100ps
`default_nettype none
interface dcm_bus_if;
  logic        ale;
  logic        rdN;
  logic        wrN;
  logic [25:0] ad;
  logic        csN;
  logic        cfgSelN;
  logic        devAckN;
  logic        devAckOeN;
  logic        devRdCEnN;
  logic        devRdCEnOeN;
  logic [31:0] rdData;
  logic        ackN;
  logic        rdCEnN;

  // pulled up when not driven
  assign ackN   = devAckOeN ? 1'b1 : devAckN;
  assign rdCEnN = devRdCEnOeN ? 1'b1 : devRdCEnN;

  modport dev (
    input  ale,
    input  rdN,
    input  wrN,
    input  ad,
    input  csN,
    input  cfgSelN,
    output devAckN,
    output devAckOeN,
    output devRdCEnN,
    output devRdCEnOeN,
    output rdData
  );
  modport host (
    output ale,
    output rdN,
    output wrN,
    output ad,
    output csN,
    output cfgSelN,
    input  ackN,
    input  rdCEnN,
    input  rdData
  );
endinterface
`default_nettype wire

// File: design/dcm_phase_timer.sv
// down counter that times one strobe phase
`timescale 1ns/100ps
`default_nettype none
module dcm_phase_timer #(
  parameter int W = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } dcm_tmr_t;

  dcm_tmr_t s;
  dcm_tmr_t next_s;

  if (W < 1) begin : g_chk
    $error("timer width must be at least one");
  end

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.cnt = loadVal;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = (s.cnt == '0);
endmodule
`default_nettype wire

// File: design/dcm_dram_ctrl.sv
// dram controller end: configuration register, select sampling, strobes, refresh
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - config bit chooses immediate or delayed select sampling
// - delayed select forces page writes of three cycles
// - unselected bus cycles are spent on refresh
// - power-up selects 512 page, non-interleaved, 25 MHz
// - power-up strobe timing 2, 4, 4, 2.5, 1.5
// - power-up image 0x6CB0, reserved bits don't care
// - sixteen-bit write-only register drives the strobes
// - decoder asserts both selects to reach register
// - plain single write cycle updates the register
// - low sixteen bus bits stored on config write
// - controller acknowledges config write after three cycles
// - outside logic never drives the acknowledge
// - upper bus bits are zero on config writes
// - reserved bits nine and fifteen written as zero
// - boot probes sizes then writes exact setup
// - every config write replaces every field
// - row timing code sets strobe width, precharge
// - column width bit picks 2.5 or 1.5
// - clock code sets the refresh timer reload
module dcm_dram_ctrl
  import dcm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  dcm_bus_if.dev          bus,
  input  wire logic [31:0] dramDataIn,
  output logic            rasN,
  output logic            casN,
  output logic            refreshActive,
  output logic [1:0]      pageSizeCode,
  output logic            interleaved,
  output logic            writeNearEnable,
  output logic            columnPrechargeLong,
  output logic [15:0]     cfgImage
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_CFG  = 3'b010,
    S_PRE  = 3'b011,
    S_RCD  = 3'b100,
    S_CAS  = 3'b101,
    S_END  = 3'b110,
    S_REF  = 3'b111
  } dcm_dstate_t;

  typedef struct packed {
    dcm_dstate_t      st;
    logic             prevAle;
    logic [15:0]      cfg;
    logic [15:0]      act;
    logic [2:0]       age;
    logic             ackN;
    logic             rdCEnN;
    logic             rasN;
    logic             casN;
    logic [31:0]      rdData;
    logic [REF_W-1:0] refCnt;
    logic             refDue;
  } dcm_dev_t;

  localparam dcm_dev_t DEV_RESET = '{
    st:      S_IDLE,
    prevAle: 1'b0,
    cfg:     CFG_RESET,
    act:     CFG_RESET,
    age:     3'h0,
    ackN:    1'b1,
    rdCEnN:  1'b1,
    rasN:    1'b1,
    casN:    1'b1,
    rdData:  32'h0,
    refCnt:  REF_W'(0),
    refDue:  1'b0
  };

  dcm_dev_t    s;
  dcm_dev_t    next_s;
  logic        tLoad;
  logic [2:0]  tVal;
  logic        tDone;
  logic        negAle;
  logic        sampleNow;
  logic        refStart;
  logic        refHit;
  logic [15:0] cur;
  logic [2:0]  rasW;
  logic [2:0]  row_to_column_delay_sel;
  logic [2:0]  casLen;
  logic        driving;

  dcm_phase_timer #(
    .W (3)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .load    (tLoad),
    .loadVal (tVal),
    .done    (tDone)
  );

  always_comb begin
    next_s = s;
    tLoad = 1'b0;
    tVal = 3'h0;
    refStart = 1'b0;
    next_s.prevAle = bus.ale;
    next_s.ackN = 1'b1;
    next_s.rdCEnN = 1'b1;
    negAle = s.prevAle && !bus.ale;
    // in idle the register in force is the stored one, later the latched copy
    cur = (s.st == S_IDLE) ? s.cfg : s.act;
    rasW = dcmRasWidth(s.act[ROW_TIMING_CODE_LO +: 3]);
    row_to_column_delay_sel = s.act[ROW_TO_COLUMN_DELAY_SEL_BIT] ? 3'h2 : 3'h1;
    casLen = s.act[COLUMN_WIDTH_SEL_BIT] ? 3'h2 : 3'h3;
    if (!bus.wrN) begin
      if (s.act[DELAYED_SELECT_SAMPLING_BIT] && casLen < PAGE_WR_MIN_SLOW) begin
        casLen = PAGE_WR_MIN_SLOW;
      end else if (casLen < PAGE_WR_MIN_FAST) begin
        casLen = PAGE_WR_MIN_FAST;
      end
    end
    // hold the row strobe for at least its programmed width
    if (casLen < rasW - row_to_column_delay_sel) begin
      casLen = rasW - row_to_column_delay_sel;
    end
    refHit = (s.refCnt == REF_W'(0));
    if (refHit) begin
      next_s.refCnt = dcmRefReload(s.cfg[REFRESH_CLOCK_CODE_LO +: 3]);
    end else begin
      next_s.refCnt = s.refCnt - REF_W'(1);
    end
    if (s.age != 3'h7) begin
      next_s.age = s.age + 3'h1;
    end
    sampleNow = (s.st == S_WAIT) ||
                (s.st == S_IDLE && negAle && !s.cfg[DELAYED_SELECT_SAMPLING_BIT]);
    case (s.st)
      S_IDLE: begin
        next_s.rasN = 1'b1;
        next_s.casN = 1'b1;
        if (negAle) begin
          next_s.act = s.cfg;
          next_s.age = 3'h1;
          if (s.cfg[DELAYED_SELECT_SAMPLING_BIT]) begin
            next_s.st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        next_s.st = S_IDLE;
      end
      S_CFG: begin
        if (s.age == CFG_ACK_CYCLES - 3'h1) begin
          next_s.ackN = 1'b0;
        end
        if (!s.ackN) begin
          if (!bus.wrN) begin
            next_s.cfg = bus.ad[15:0];
          end
          next_s.st = S_IDLE;
        end
      end
      S_PRE: begin
        if (tDone) begin
          next_s.st = S_RCD;
          next_s.rasN = 1'b0;
          tLoad = 1'b1;
          tVal = row_to_column_delay_sel - 3'h1;
        end
      end
      S_RCD: begin
        if (tDone) begin
          next_s.st = S_CAS;
          next_s.casN = 1'b0;
          tLoad = 1'b1;
          tVal = casLen - 3'h1;
        end
      end
      S_CAS: begin
        if (tDone) begin
          next_s.st = S_END;
          next_s.rasN = 1'b1;
          next_s.casN = 1'b1;
          next_s.ackN = 1'b0;
          next_s.rdCEnN = bus.rdN;
          next_s.rdData = dramDataIn;
        end
      end
      S_END: begin
        next_s.st = S_IDLE;
      end
      S_REF: begin
        if (tDone) begin
          next_s.rasN = 1'b1;
          next_s.st = S_IDLE;
        end
      end
      default: begin
        next_s.st = S_IDLE;
      end
    endcase
    if (sampleNow) begin
      if (!bus.csN && !bus.cfgSelN) begin
        next_s.st = S_CFG;
      end else if (!bus.csN) begin
        next_s.st = S_PRE;
        tLoad = 1'b1;
        tVal = dcmRasPre(cur[ROW_TIMING_CODE_LO +: 3]) - 3'h2;
      end else if (s.refDue) begin
        next_s.st = S_REF;
        next_s.rasN = 1'b0;
        refStart = 1'b1;
        tLoad = 1'b1;
        tVal = dcmRasWidth(cur[ROW_TIMING_CODE_LO +: 3]) - 3'h1;
      end else begin
        next_s.st = S_IDLE;
      end
    end
    // a new refresh demand beats the clear of the old one
    next_s.refDue = refHit || (s.refDue && !refStart);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= DEV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // acknowledge and read enable are only driven for our own accesses
  assign driving = (s.st == S_CFG) || (s.st == S_PRE) || (s.st == S_RCD) ||
                   (s.st == S_CAS) || (s.st == S_END);
  assign bus.devAckN     = s.ackN;
  assign bus.devAckOeN   = !driving;
  assign bus.devRdCEnN   = s.rdCEnN;
  assign bus.devRdCEnOeN = !driving;
  assign bus.rdData      = s.rdData;

  assign rasN                = s.rasN;
  assign casN                = s.casN;
  assign refreshActive       = (s.st == S_REF);
  assign pageSizeCode        = s.act[PAGE_SIZE_CODE_LO +: 2];
  assign interleaved         = s.act[INTERLEAVE_BIT];
  assign writeNearEnable     = !s.act[WRITE_NEAR_DISABLE_BIT];
  assign columnPrechargeLong = s.act[COLUMN_PRECHARGE_SEL_BIT];
  assign cfgImage            = s.cfg;
endmodule
`default_nettype wire

// File: design/dcm_host.sv
// host end: wishbone slave that runs single bus cycles and acts as address decoder
`timescale 1ns/100ps
`default_nettype none
module dcm_host
  import dcm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  dcm_bus_if.host          bus
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ALE  = 2'b01,
    H_XFER = 2'b10,
    H_REL  = 2'b11
  } dcm_hstate_t;

  typedef struct packed {
    dcm_hstate_t st;
    logic [25:0] cmdAddr;
    logic [31:0] cmdData;
    dcm_kind_t   kind;
    logic        busy;
    logic        done;
    logic [31:0] rdData;
    logic        wbAck;
    logic [31:0] wbDat;
    logic [2:0]  cnt;
    logic        ale;
    logic        rdN;
    logic        wrN;
    logic [25:0] ad;
    logic        csN;
    logic        cfgSelN;
  } dcm_host_t;

  localparam dcm_host_t HOST_RESET = '{
    st: H_IDLE, cmdAddr: 26'h0, cmdData: 32'h0, kind: K_MEMWR, busy: 1'b0,
    done: 1'b0, rdData: 32'h0, wbAck: 1'b0, wbDat: 32'h0, cnt: 3'h0,
    ale: 1'b0, rdN: 1'b1, wrN: 1'b1, ad: 26'h0, csN: 1'b1, cfgSelN: 1'b1
  };

  dcm_host_t s;
  dcm_host_t next_s;
  logic      wrTake;

  always_comb begin
    next_s = s;
    next_s.wbAck = cyc_i && stb_i && !s.wbAck;
    wrTake = cyc_i && stb_i && we_i && s.wbAck && sel_i != 4'h0;
    if (cyc_i && stb_i && !s.wbAck) begin
      case (adr_i)
        REG_ADDR:   next_s.wbDat = {6'h0, s.cmdAddr};
        REG_DATA:   next_s.wbDat = s.cmdData;
        REG_STATUS: next_s.wbDat = {30'h0, s.done, s.busy};
        REG_RDDATA: next_s.wbDat = s.rdData;
        default:    next_s.wbDat = 32'h0;
      endcase
    end
    if (wrTake && adr_i == REG_ADDR) begin
      next_s.cmdAddr = dat_i[25:0];
    end
    if (wrTake && adr_i == REG_DATA) begin
      next_s.cmdData = dat_i;
    end
    case (s.st)
      H_IDLE: begin
        if (wrTake && adr_i == REG_CTRL && dat_i[CTRL_GO]) begin
          next_s.kind = dcm_kind_t'(dat_i[CTRL_KIND +: 2]);
          next_s.busy = 1'b1;
          next_s.done = 1'b0;
          next_s.st = H_ALE;
          next_s.ale = 1'b1;
          next_s.ad = s.cmdAddr;
          next_s.csN = (dat_i[CTRL_KIND +: 2] == K_OTHER);
          next_s.cfgSelN = (dat_i[CTRL_KIND +: 2] != K_CFGWR);
        end
      end
      H_ALE: begin
        next_s.ale = 1'b0;
        next_s.st = H_XFER;
        next_s.cnt = 3'h0;
        next_s.rdN = (s.kind != K_MEMRD);
        next_s.wrN = (s.kind == K_MEMRD);
        if (s.kind == K_CFGWR) begin
          next_s.ad = {10'h0, s.cmdData[15:0] & ~CFG_RSVD};
        end else begin
          next_s.ad = s.cmdData[25:0];
        end
      end
      H_XFER: begin
        next_s.cnt = s.cnt + 3'h1;
        // the acknowledge is only watched here, the device supplies it
        if (s.kind == K_OTHER) begin
          if (s.cnt == OTHER_CYCLES - 3'h1) begin
            next_s.st = H_REL;
          end
        end else if (!bus.ackN) begin
          next_s.st = H_REL;
          if (s.kind == K_MEMRD) begin
            next_s.rdData = bus.rdData;
          end
        end
        if (next_s.st == H_REL) begin
          next_s.rdN = 1'b1;
          next_s.wrN = 1'b1;
          next_s.csN = 1'b1;
          next_s.cfgSelN = 1'b1;
        end
      end
      H_REL: begin
        next_s.st = H_IDLE;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
      default: begin
        next_s.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= HOST_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign dat_o       = s.wbDat;
  assign ack_o       = s.wbAck;
  assign bus.ale     = s.ale;
  assign bus.rdN     = s.rdN;
  assign bus.wrN     = s.wrN;
  assign bus.ad      = s.ad;
  assign bus.csN     = s.csN;
  assign bus.cfgSelN = s.cfgSelN;
endmodule
`default_nettype wire

// File: verification/dcm_bus_sva.sv
// concurrent checks on the processor bus between host and dram controller ends
`timescale 1ns/100ps
`default_nettype none
module dcm_bus_sva (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        ale,
  input wire logic        rdN,
  input wire logic        wrN,
  input wire logic [25:0] ad,
  input wire logic        csN,
  input wire logic        cfgSelN,
  input wire logic        ackN,
  input wire logic        rdCEnN
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence cfgWrStart;
    $fell(ale) && !csN && !cfgSelN && !wrN;
  endsequence

  cfg_ack_three_a: assert property (cfgWrStart |=> ackN ##1 ackN ##1 !ackN)
    else $error("config write ack not on third cycle");
  ack_one_cycle_a: assert property ($fell(ackN) |=> ackN)
    else $error("ack held longer than one cycle");
  ack_needs_cs_a: assert property (!ackN |-> !csN)
    else $error("ack driven without controller select");
  rdcen_needs_cs_a: assert property (!rdCEnN |-> !csN && !rdN)
    else $error("read enable driven outside a selected read");
  both_selects_a: assert property (!cfgSelN |-> !csN)
    else $error("register select without controller select");
  cfg_zero_bits_a: assert property (!cfgSelN && !wrN && !ale |-> ad[25:16] == 10'h000 && !ad[15] && !ad[9])
    else $error("config write data has nonzero upper or reserved bits");
  single_write_a: assert property (!wrN |-> rdN)
    else $error("read and write strobes both low");
  wr_held_a: assert property (!wrN && ackN && !csN |=> !wrN && $stable(ad))
    else $error("write released before ack");
  rd_held_a: assert property (!rdN && ackN && !csN |=> !rdN)
    else $error("read released before ack");
  ale_pulse_a: assert property ($rose(ale) |=> !ale)
    else $error("address latch enable longer than one cycle");

  cov_cfg_wr: cover property (cfgWrStart ##3 !ackN);
  cov_rd_ack: cover property (!rdN && !csN && !ackN);
  cov_rdcen: cover property (!rdCEnN);
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench: wishbone host end driving the dram controller end
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dcm_pkg::*;
  logic        clk_sys, reset, cyc, stb, we, ack;
  logic        rasN, casN, refA, ilv, wne, cpl, rasSeen, refSeen;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR, dIn;
  logic [1:0]  psc;
  logic [15:0] img;
  int          casCnt, failures, checks;
  // pages of four, interleaved, write-near off, row code 0, narrow column, delayed select
  localparam logic [15:0] V1 = 16'h690F;

  dcm_bus_if bus ();
  dcm_host u_dcm_host (.clk_sys(clk_sys), .reset(reset), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(datW), .sel_i(sel), .dat_o(datR), .ack_o(ack),
    .bus(bus.host));
  dcm_dram_ctrl u_dcm_dram_ctrl (.clk_sys(clk_sys), .reset(reset), .bus(bus.dev),
    .dramDataIn(dIn), .rasN(rasN), .casN(casN), .refreshActive(refA), .pageSizeCode(psc),
    .interleaved(ilv), .writeNearEnable(wne), .columnPrechargeLong(cpl), .cfgImage(img));
  dcm_bus_sva u_sva (.clk_sys(clk_sys), .reset(reset), .ale(bus.ale), .rdN(bus.rdN),
    .wrN(bus.wrN), .ad(bus.ad), .csN(bus.csN), .cfgSelN(bus.cfgSelN), .ackN(bus.ackN),
    .rdCEnN(bus.rdCEnN));

  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // strobe and refresh activity seen since the last clear
  always @(posedge clk_sys) begin
    if (rasN === 1'h0) rasSeen <= 1'h1;
    if (casN === 1'h0) casCnt <= casCnt + 1;
    if (refA === 1'h1) refSeen <= 1'h1;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    datW <= d;
    sel <= 4'hF;
    // no cycle count is assumed: only the watchdog ends this wait
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'h1);
    q = datR;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic cmd(input logic [1:0] k, input logic [31:0] d);
    logic [31:0] q;
    int n;
    wb(1'h1, REG_ADDR, 32'h0000_0100, q);
    wb(1'h1, REG_DATA, d, q);
    wb(1'h1, REG_CTRL, {29'h0, k, 1'h1}, q);
    n = 0;
    do begin
      wb(1'h0, REG_STATUS, 32'h0, q);
      n++;
    end while (!(q[STAT_DONE] === 1'h1 && q[STAT_BUSY] === 1'h0) && n < 100);
    if (n >= 100) failures++;
  endtask

  task clrMon;
    @(negedge clk_sys);
    rasSeen = 1'h0;
    refSeen = 1'h0;
    casCnt = 0;
    @(posedge clk_sys);
  endtask

  task tReset;
    check("image", img, CFG_RESET);
    check("image", img & ~CFG_RSVD, 16'h6CB0);
    check("page", psc, 2'h0);
    check("ilv", ilv, 1'h0);
    check("wne", wne, 1'h1);
    check("cpl", cpl, 1'h1);
    check("ras", rasN, 1'h1);
  endtask

  task tUnmapped;
    logic [31:0] q;
    wb(1'h1, 8'h40, 32'hFFFF_FFFF, q);
    wb(1'h0, 8'h40, 32'h0, q);
    check("unmapped", q, 32'h0);
  endtask

  task tCfg;
    clrMon;
    cmd(K_CFGWR, 32'hFFFF_0000 | V1 | CFG_RSVD);
    check("image", img, V1);
    check("cfg ras", rasSeen, 1'h0);
    check("old page", psc, 2'h0);
    cmd(K_OTHER, 32'h0);
    check("refresh", refSeen, 1'h1);
    check("page", psc, 2'h3);
    check("ilv", ilv, 1'h1);
    check("wne", wne, 1'h0);
    check("cpl", cpl, 1'h0);
  endtask

  task tMemWr;
    clrMon;
    cmd(K_MEMWR, 32'h1234_5678);
    check("ras", rasSeen, 1'h1);
    check("slow page", casCnt >= 3, 1'h1);
  endtask

  task tMemRd;
    logic [31:0] q;
    cmd(K_MEMRD, 32'h0);
    wb(1'h0, REG_RDDATA, 32'h0, q);
    check("rddata", q, 32'h5A3C_96E1);
  endtask

  task tCfgClear;
    cmd(K_CFGWR, 32'h0);
    check("image", img, 16'h0000);
    cmd(K_OTHER, 32'h0);
    check("wne", wne, 1'h1);
    check("page", psc, 2'h0);
    // immediate select sampling in force: config write and a narrow-column page write
    cmd(K_CFGWR, 32'h0000_0100);
    check("image", img, 16'h0100);
    clrMon;
    cmd(K_MEMWR, 32'h0000_00A5);
    check("fast page", casCnt, 32'h2);
  endtask

  task wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    reset = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    sel = 4'h0;
    datW = 32'h0;
    dIn = 32'h5A3C_96E1;
    rasSeen = 1'h0;
    refSeen = 1'h0;
    casCnt = 0;
    failures = 0;
    checks = 0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    tReset;
    tUnmapped;
    tCfg;
    tMemWr;
    tMemRd;
    tCfgClear;
    wrap_up;
  end

  // cut a hang short well beyond the length of the scenarios
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
